/* src/ssla_top.sv */
// Parameter-set sequencer advanced by a selected input line at frame start
// ==========================================================
`timescale 1ns/1ns
module ssla_top (
   // Clock, reset, enable
   input  wire logic                          mclk_i,
   input  wire logic                          rst_n_i,
   input  wire logic                          ce_i,
   // Register bus
   input  wire ssla_pkg::ssla_wb_req_t        wb_req_i,
   output      ssla_pkg::ssla_wb_rsp_t        wb_rsp_o,
   // Input lines and frame trigger
   input  wire logic                          line1_i,
   input  wire logic                          line2_i,
   input  wire logic                          frame_trig_i,
   // Sequencer state
   output      logic                          waiting_o,
   output      logic                          frame_acc_o,
   output      logic [ssla_pkg::IDX_W-1:0]    set_index_o,
   output      logic [ssla_pkg::PAR_W-1:0]    active_o
);
   import ssla_pkg::*;

   // ==========================================================
   // Helpers
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction

   // Out-of-range totals are pinned to 1..64 so an index can never escape
   function automatic logic [TOT_W-1:0] clamp_total(input logic [31:0] v);
      if (v[TOT_W-1:0] == '0) begin
         return TOTAL_RST;
      end else if (v[31:TOT_W] != '0 || v[TOT_W-1:0] > TOT_W'(MAX_SETS)) begin
         return TOT_W'(MAX_SETS);
      end else begin
         return v[TOT_W-1:0];
      end
   endfunction

   // ==========================================================
   // State
   logic                 en;
   logic                 sel_line2;
   logic                 invert;
   logic [TOT_W-1:0]     total;
   logic [IDX_W-1:0]     setsel;
   logic [IDX_W-1:0]     idx;
   logic [PAR_W-1:0]     active;
   logic [PAR_W-1:0]     saved;
   logic [CNT_W-1:0]     cnt;
   logic                 waiting;
   logic                 trig_q;
   logic                 lvl_q;
   logic                 acc;
   logic                 ack;
   logic [31:0]          rdat;
   logic [PAR_W-1:0]     mem [MAX_SETS];

   // ==========================================================
   // Bus decode
   wire                  hit     = wb_req_i.cyc & wb_req_i.stb & ~ack;
   // Writes land on the edge where ack is sampled high, so a master that
   // drops its request before ack leaves no trace
   wire                  wr      = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & ack;
   wire                  wr_ctrl = wr & (wb_req_i.adr == OFS_CTRL);
   wire                  wr_tot  = wr & (wb_req_i.adr == OFS_TOTAL);
   wire                  wr_sel  = wr & (wb_req_i.adr == OFS_SETSEL);
   wire                  wr_dat  = wr & (wb_req_i.adr == OFS_SETDAT);
   wire                  wr_act  = wr & (wb_req_i.adr == OFS_ACTIVE) & ~en;
   wire [31:0]           ctrl_rd = {29'h0, invert, sel_line2, en};
   wire [31:0]           ctrl_wv = merge(ctrl_rd, wb_req_i.dat, wb_req_i.sel);
   wire [31:0]           tot_wv  = merge({25'h0, total}, wb_req_i.dat, wb_req_i.sel);
   wire [31:0]           sel_wv  = merge({26'h0, setsel}, wb_req_i.dat, wb_req_i.sel);
   wire [31:0]           dat_wv  = merge({16'h0, mem[setsel]}, wb_req_i.dat, wb_req_i.sel);
   wire [31:0]           act_wv  = merge({16'h0, active}, wb_req_i.dat, wb_req_i.sel);
   wire                  en_new  = ctrl_wv[CTRL_EN_BIT];
   wire                  en_rise = wr_ctrl & en_new & ~en;
   wire                  en_fall = wr_ctrl & ~en_new & en;
   wire [31:0]           stat_rd = {22'h0, en, waiting, 2'h0, idx};

   // Read mux; unmapped offsets answer zero
   wire [31:0]           rd_mux  =
      (wb_req_i.adr == OFS_CTRL)   ? ctrl_rd :
      (wb_req_i.adr == OFS_TOTAL)  ? {25'h0, total} :
      (wb_req_i.adr == OFS_STATUS) ? stat_rd :
      (wb_req_i.adr == OFS_SETSEL) ? {26'h0, setsel} :
      (wb_req_i.adr == OFS_SETDAT) ? {16'h0, mem[setsel]} :
      (wb_req_i.adr == OFS_ACTIVE) ? {16'h0, active} : 32'h0;

   // ==========================================================
   // Line and trigger decode
   // only the chosen line
   wire                  sel_lvl  = sel_line2 ? line2_i : line1_i;
   wire                  ctl_lvl  = sel_lvl ^ invert;
   wire                  line_chg = sel_lvl ^ lvl_q;
   wire                  trig_rise = frame_trig_i & ~trig_q;
   wire                  take     = en & waiting & trig_rise & ~line_chg & ~wr_ctrl;
   wire                  adv      = take & ctl_lvl;
   // highest index is total minus one
   // Greater-or-equal so a total shrunk while running still wraps cleanly
   wire                  last     = ({1'b0, idx} >= total - TOT_W'(1));
   wire [IDX_W-1:0]      next_idx = last ? '0 : idx + IDX_W'(1);
   // settle window on each line change
   wire [CNT_W-1:0]      next_cnt = line_chg ? CNT_W'(SETTLE_CYC) :
                                    (cnt != '0) ? cnt - CNT_W'(1) : cnt;
   wire                  next_waiting = en & ~line_chg & (next_cnt == '0) & ~en_fall;

   // ==========================================================
   // Register and bus flops
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         ack       <= 1'b0;
         rdat      <= 32'h0;
         sel_line2 <= 1'b0;
         invert    <= 1'b0;
         total     <= TOTAL_RST;
         setsel    <= '0;
      end else if (ce_i) begin
         ack  <= hit;
         rdat <= hit ? rd_mux : 32'h0;
         if (wr_ctrl) begin
            sel_line2 <= ctrl_wv[CTRL_LINE_BIT];
            invert    <= ctrl_wv[CTRL_INV_BIT];
         end
         if (wr_tot) begin
            total <= clamp_total(tot_wv);
         end
         if (wr_sel) begin
            setsel <= sel_wv[IDX_W-1:0];
         end
      end
   end

   // Set store has no reset; software fills it before enabling
   always_ff @(posedge mclk_i) begin
      if (ce_i && wr_dat) begin
         mem[setsel] <= dat_wv[PAR_W-1:0];
      end
   end

   // ==========================================================
   // Sequencer flops
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         en     <= 1'b0;
         idx    <= '0;
         active <= ACTIVE_RST;
         saved  <= ACTIVE_RST;
         acc    <= 1'b0;
      end else if (ce_i) begin
         acc <= take;
         if (en_rise) begin
            en     <= 1'b1;
            saved  <= active;
            idx    <= '0;
            active <= mem[0];
         end else if (en_fall) begin
            en     <= 1'b0;
            idx    <= '0;
            active <= saved;
         end else if (wr_act) begin
            active <= act_wv[PAR_W-1:0];
         end else if (adv) begin
            idx    <= next_idx;
            active <= mem[next_idx];
         end
         // low level holds: no branch taken
      end
   end

   // Trigger edge and settle timer
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         trig_q  <= 1'b0;
         lvl_q   <= 1'b0;
         cnt     <= '0;
         waiting <= 1'b0;
      end else if (ce_i) begin
         trig_q  <= frame_trig_i;
         lvl_q   <= sel_lvl;
         cnt     <= next_cnt;
         waiting <= next_waiting;
      end
   end

   // ==========================================================
   // Outputs
   assign wb_rsp_o.ack = ack;
   assign wb_rsp_o.dat = rdat;
   assign waiting_o    = waiting;
   assign frame_acc_o  = acc;
   assign set_index_o  = idx;
   assign active_o     = active;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   logic [PAR_W-1:0] mem0_q;
   always_ff @(posedge mclk_i) begin
      mem0_q <= mem[0];
   end

   idx_range_a: assert property (en |-> ({1'b0, idx} < total))
      else $error("Active index beyond total");
   total_cap_a: assert property (total != '0 && total <= TOT_W'(MAX_SETS))
      else $error("Total outside 1..64");
   low_hold_a: assert property (ce_i && take && !ctl_lvl |=> $stable(idx) && $stable(active))
      else $error("Low line changed the set");
   step_up_a: assert property (ce_i && adv && !last |=> idx == $past(idx) + IDX_W'(1))
      else $error("Advance did not step by one");
   wrap_zero_a: assert property (ce_i && adv && last |=> idx == '0 && active == mem0_q)
      else $error("Wrap did not return to set 0");
   enable_load_a: assert property (ce_i && en_rise |=> en && idx == '0 && active == mem0_q)
      else $error("Enable did not load set 0");
   disable_restore_a: assert property (ce_i && en_fall
                                       |=> !en && active == $past(saved))
      else $error("Disable did not restore active set");
   settle_drop_a: assert property (ce_i && en && line_chg |=> !waiting_o)
      else $error("Waiting kept during line change");
   ignore_trig_a: assert property (ce_i && trig_rise && !waiting && !wr_ctrl && !wr_act
                                   |=> $stable(idx) && !frame_acc_o)
      else $error("Trigger taken while not waiting");
   line_only_a: assert property (ce_i && en && !trig_rise && !wr_ctrl && !wr_act
                                 |=> $stable(idx))
      else $error("Set changed without a trigger");

   // ==========================================================
   // Decision and settle assertions
   logic [CNT_W:0]   quiet;
   logic [PAR_W-1:0] next_set_q;

   // Edges since the last line change; saturates so it never wraps
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         quiet <= '0;
      end else if (ce_i) begin
         if (!en || line_chg) begin
            quiet <= '0;
         end else if (quiet != '1) begin
            quiet <= quiet + (CNT_W+1)'(1);
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      next_set_q <= mem[next_idx];
   end

   // One decision per trigger
   acc_pulse_a: assert property (ce_i && frame_acc_o |=> !frame_acc_o)
      else $error("Accept pulse longer than one cycle");

   // A trigger meeting a line change is dropped
   change_drop_a: assert property (ce_i && trig_rise && line_chg |=> !frame_acc_o)
      else $error("Trigger taken during line change");

   // No accept without a waiting trigger
   no_accept_a: assert property (ce_i && !(en && waiting && trig_rise) |=> !frame_acc_o)
      else $error("Accept without waiting trigger");

   // Each change restarts the full settle window
   cnt_load_a: assert property (ce_i && line_chg |=> cnt == CNT_W'(SETTLE_CYC))
      else $error("Settle count not loaded");

   // Waiting returns as the window closes
   wait_back_a: assert property (ce_i && en && !line_chg && !wr_ctrl && cnt == CNT_W'(1)
                                 |=> waiting_o)
      else $error("Waiting not restored after settle");

   // A rested line never leaves waiting low
   quiet_wait_a: assert property (ce_i && en && quiet > (CNT_W+1)'(SETTLE_CYC)
                                  |-> waiting_o)
      else $error("Waiting missing on a quiet line");

   // Disabled block neither waits nor accepts
   off_idle_a: assert property (ce_i && !en |=> !waiting_o && !frame_acc_o)
      else $error("Activity while disabled");

   // Index restarts on disable
   idx_clear_a: assert property (ce_i && en_fall |=> idx == '0)
      else $error("Index not cleared on disable");

   // Only a decision may touch the active set while running
   act_lock_a: assert property (ce_i && en && !en_fall && !adv |=> $stable(active))
      else $error("Active set changed without advance");

   // Decision follows the pin level through the inversion
   inv_decide_a: assert property (ce_i && take && total != TOT_W'(1) && {1'b0, idx} < total
                                  |=> (idx != $past(idx))
                                      == $past((sel_line2 ? line2_i : line1_i) ^ invert))
      else $error("Decision ignores line inversion");

   // An advance loads the stored next set
   step_load_a: assert property (ce_i && adv |=> active == next_set_q)
      else $error("Advance loaded the wrong set");

   // Low enable freezes the sequencer
   freeze_a: assert property (!ce_i |=> $stable(idx) && $stable(active) && $stable(waiting_o))
      else $error("State moved while frozen");

   adv_seen_c:  cover property (ce_i && adv && !last);
   wrap_seen_c: cover property (ce_i && adv && last);
   drop_seen_c: cover property (ce_i && en && trig_rise && !waiting);
   hold_seen_c: cover property (ce_i && take && !ctl_lvl);
   restore_seen_c: cover property (ce_i && en_fall);

endmodule

/* src/ssla_pkg.sv */
// Shared constants and carrier types for the line-driven set sequencer
package ssla_pkg;

   // ==========================================================
   // Timing
   localparam int          CLK_PERIOD_NS = 40;
   localparam int          SETTLE_NS     = 1000;
   localparam int          SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          CNT_W         = 5;

   // ==========================================================
   // Set store geometry
   localparam int          MAX_SETS      = 64;
   localparam int          IDX_W         = 6;
   localparam int          TOT_W         = 7;
   localparam int          PAR_W         = 16;

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0]  OFS_CTRL      = 8'h00;
   localparam logic [7:0]  OFS_TOTAL     = 8'h04;
   localparam logic [7:0]  OFS_STATUS    = 8'h08;
   localparam logic [7:0]  OFS_SETSEL    = 8'h0C;
   localparam logic [7:0]  OFS_SETDAT    = 8'h10;
   localparam logic [7:0]  OFS_ACTIVE    = 8'h14;

   // ==========================================================
   // Field positions
   localparam int          CTRL_EN_BIT   = 0;
   localparam int          CTRL_LINE_BIT = 1;
   localparam int          CTRL_INV_BIT  = 2;
   localparam int          STAT_WAIT_BIT = 8;
   localparam int          STAT_EN_BIT   = 9;

   // ==========================================================
   // Reset values
   localparam logic [TOT_W-1:0] TOTAL_RST = 7'h01;
   localparam logic [PAR_W-1:0] ACTIVE_RST = 16'h0000;

   // ==========================================================
   // Wishbone carriers
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } ssla_wb_req_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } ssla_wb_rsp_t;

endpackage

/* verif/ssla_far_end.sv */
// Far-side model: drives both input lines and the frame trigger
`timescale 1ns/1ns
module ssla_far_end
   import ssla_pkg::*;
(
   // Clock and status
   input  wire logic mclk_i,
   input  wire logic waiting_i,
   // Lines and trigger
   output logic      line1_o,
   output logic      line2_o,
   output logic      trig_o
);
   initial begin
      line1_o = 1'b0;
      line2_o = 1'b0;
      trig_o  = 1'b0;
   end

   // ==========================================================
   // One frame; early breaks the settle and hold rules on purpose
   task automatic frame(input logic sel, input logic lvl, input logic early);
      int n;
      n = 0;
      @(posedge mclk_i);
      if (sel) begin
         line2_o <= lvl;
      end else begin
         line1_o <= lvl;
      end
      if (!early) begin
         // Status reacts one edge after the line moves
         @(posedge mclk_i);
         while (waiting_i !== 1'b1 && n < 200) begin
            @(posedge mclk_i);
            n++;
         end
         repeat (SETTLE_CYC) @(posedge mclk_i);
      end
      @(posedge mclk_i);
      trig_o <= 1'b1;
      repeat (early ? 3 : SETTLE_CYC + 1) @(posedge mclk_i);
      trig_o <= 1'b0;
      @(posedge mclk_i);
   endtask
endmodule

/* verif/testbench.sv */
// Self-checking bench for the line-driven set sequencer
`timescale 1ns/1ns
module testbench;
   import ssla_pkg::*;
   logic             mclk_i;
   logic             rst_n_i;
   logic             ce_i;
   logic             line1;
   logic             line2;
   logic             trig;
   logic             waiting;
   logic             acc;
   ssla_wb_req_t     req;
   ssla_wb_rsp_t     rsp;
   logic [IDX_W-1:0] idx;
   logic [PAR_W-1:0] act;
   logic [31:0]      rd;
   int               bad_count;
   int               checked;
   int               acc_n;
   int               exp_i;

   ssla_top dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .wb_req_i(req),
      .wb_rsp_o(rsp), .line1_i(line1), .line2_i(line2), .frame_trig_i(trig),
      .waiting_o(waiting), .frame_acc_o(acc), .set_index_o(idx), .active_o(act));
   ssla_far_end fe (.mclk_i(mclk_i), .waiting_i(waiting), .line1_o(line1),
      .line2_o(line2), .trig_o(trig));

   initial begin
      mclk_i = 1'b0;
      forever #20 mclk_i = ~mclk_i;
   end

   always @(posedge mclk_i) begin
      if (acc === 1'b1) begin
         acc_n <= acc_n + 1;
      end
   end

   // ==========================================================
   // Shared tasks
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Classic cycle: hold until ack is sampled, then release
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk_i);
      req <= '{cyc:1'b1, stb:1'b1, we:w, adr:a, sel:4'hF, dat:d};
      do begin
         @(posedge mclk_i);
         n++;
      end while (rsp.ack !== 1'b1 && n < 50);
      rd = rsp.dat;
      req <= '0;
      if (n >= 50) bad_count++;
   endtask

   task automatic frame_chk(input logic sel, input logic lvl, input logic inv);
      int a0;
      a0 = acc_n;
      if (lvl ^ inv) exp_i = (exp_i + 1) % 6;
      fe.frame(sel, lvl, 1'b0);
      check("pulses", acc_n - a0, 1);
      check("index", idx, exp_i);
      check("active", act, 32'hA000 + exp_i);
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_regs();
      wb(1'b0, OFS_TOTAL, 32'h0);
      check("total reset", rd, 32'h1);
      wb(1'b0, 8'h40, 32'h0);
      check("unmapped", rd, 32'h0);
      wb(1'b1, OFS_TOTAL, 32'h64);
      wb(1'b0, OFS_TOTAL, 32'h0);
      check("total limit", rd, 32'h40);
      wb(1'b1, OFS_TOTAL, 32'h6);
      wb(1'b1, OFS_ACTIVE, 32'h5A5A);
      for (int i = 0; i < 6; i++) begin
         wb(1'b1, OFS_SETSEL, i);
         wb(1'b1, OFS_SETDAT, 32'hA000 + i);
      end
      wb(1'b1, OFS_CTRL, 32'h1);
      exp_i = 0;
      @(posedge mclk_i);
      check("enable index", idx, 32'h0);
      check("enable active", act, 32'hA000);
      wb(1'b0, OFS_STATUS, 32'h0);
      check("status", rd, 32'h300);
   endtask

   // Level pattern walks past the top index and wraps
   task automatic t_seq();
      logic [9:0] pat;
      pat = 10'h2F2;
      for (int i = 0; i < 10; i++) begin
         frame_chk(1'b0, pat[i], 1'b0);
      end
   endtask

   task automatic t_early();
      int a0;
      a0 = acc_n;
      fe.frame(1'b0, 1'b0, 1'b1);
      check("waiting drop", waiting, 32'h0);
      check("ignored", acc_n - a0, 0);
      check("ignored index", idx, exp_i);
      ce_i <= 1'b0;
      fe.frame(1'b0, 1'b1, 1'b1);
      check("frozen index", idx, exp_i);
      ce_i <= 1'b1;
      frame_chk(1'b0, 1'b0, 1'b0);
      frame_chk(1'b0, 1'b1, 1'b0);
   endtask

   // Line 1 stays high, so only line 2 may steer the decision
   task automatic t_inv();
      wb(1'b1, OFS_CTRL, 32'h7);
      wb(1'b1, OFS_ACTIVE, 32'h1234);
      @(posedge mclk_i);
      check("active locked", act, 32'hA000 + exp_i);
      frame_chk(1'b1, 1'b0, 1'b1);
      frame_chk(1'b1, 1'b1, 1'b1);
   endtask

   task automatic t_disable();
      wb(1'b1, OFS_CTRL, 32'h0);
      @(posedge mclk_i);
      check("restored", act, 32'h5A5A);
      check("stopped", idx, 32'h0);
      wb(1'b0, OFS_STATUS, 32'h0);
      check("status off", rd, 32'h0);
   endtask

   task automatic complete_run();
      if (bad_count == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      bad_count = 0;
      checked   = 0;
      acc_n     = 0;
      exp_i     = 0;
      req       = '0;
      ce_i      = 1'b1;
      rst_n_i   = 1'b0;
      repeat (4) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      t_regs();
      t_seq();
      t_early();
      t_inv();
      t_disable();
      complete_run();
   end

   // Whole run needs about 900 cycles
   initial begin
      repeat (20000) @(posedge mclk_i);
      bad_count++;
      complete_run();
   end
endmodule
